/* shared/rps_cfg.svh */
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH

// timing, all times in ns, counts rounded up to whole core cycles
`define RPS_CLK_PERIOD_NS   4
`define RPS_RESET_TIME_NS   100000
`define RPS_PULSE_TIME_NS   1000
`define RPS_OSC_SETTLE_NS   200000
`define RPS_RX_STARTUP_NS   300000
`define RPS_CYC(t)          (((t) + `RPS_CLK_PERIOD_NS - 1) / `RPS_CLK_PERIOD_NS)
`define RPS_RESET_CYC       `RPS_CYC(`RPS_RESET_TIME_NS)
`define RPS_PULSE_CYC       `RPS_CYC(`RPS_PULSE_TIME_NS)
`define RPS_OSC_SETTLE_CYC  `RPS_CYC(`RPS_OSC_SETTLE_NS)
`define RPS_RF_UP_CYC       `RPS_CYC(`RPS_RX_STARTUP_NS - `RPS_OSC_SETTLE_NS)
`define RPS_TMR_W           20

// register byte offsets
`define RPS_OFS_CTRL        8'h00
`define RPS_OFS_STAT0       8'h04
`define RPS_OFS_STAT1       8'h08
`define RPS_OFS_MASK0       8'h0c
`define RPS_OFS_MASK1       8'h10
`define RPS_OFS_STATE       8'h14
`define RPS_OFS_ON          8'h18
`define RPS_OFS_OFF         8'h1c

// control fields and reset values
`define RPS_CTRL_POL_BIT    4
`define RPS_CTRL_WMASK      8'h1f
`define RPS_CTRL_RESET      8'h00
`define RPS_MASK_RESET      8'h00
`define RPS_STAT_RESET      8'hff
`define RPS_ON_RESET        16'h0100
`define RPS_OFF_RESET       16'h0400
`define RPS_RESP_OKAY       2'h0
`define RPS_RESP_DECERR     2'h3

`endif

/* shared/rps_pkg.sv */
`default_nettype none
package rps_pkg;
	typedef enum logic [3:0] {
		RPS_ST_OFF, RPS_ST_BROWN, RPS_ST_PULSE, RPS_ST_HOLD, RPS_ST_SLEEP,
		RPS_ST_SETTLE, RPS_ST_RFUP, RPS_ST_RX, RPS_ST_POLL_OFF
	} rps_state_t;
	typedef enum logic [1:0] {
		RPS_MODE_SLEEP, RPS_MODE_RUN, RPS_MODE_POLL, RPS_MODE_RSVD
	} rps_mode_t;
endpackage
`default_nettype wire

/* shared/rps_timer_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface rps_timer_if #(parameter int W = 20);
	logic         start;
	logic         stop;
	logic [W-1:0] load;
	logic         done;
	logic         busy;
	modport ctrl (output start, stop, load, input done, busy);
	modport tmr (input start, stop, load, output done, busy);
endinterface
`default_nettype wire

/* hdl/rps_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module rps_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,    // core clock
	input  wire logic         arst_n, // async reset
	input  wire logic [W-1:0] d,      // asynchronous levels
	output logic      [W-1:0] q       // synchronised levels
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule
`default_nettype wire

/* hdl/rps_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module rps_timer (
	input  wire logic clk,    // core clock
	input  wire logic arst_n, // async reset
	rps_timer_if.tmr  t       // start/stop/load in, done/busy out
);
	localparam int W = $bits(t.load);
	logic [W-1:0] cnt_reg;

	// done pulses load cycles after start; start while busy restarts
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= '0;
			t.busy  <= 1'b0;
			t.done  <= 1'b0;
		end else begin
			t.done <= 1'b0;
			if (t.stop) begin
				t.busy <= 1'b0;
			end else if (t.start) begin
				cnt_reg <= t.load;
				t.busy  <= 1'b1;
			end else if (t.busy) begin
				if (cnt_reg <= W'(1)) begin
					t.busy <= 1'b0;
					t.done <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - W'(1);
				end
			end
		end
	end

	property p_done_after_busy;
		@(posedge clk) disable iff (!arst_n)
		t.done |-> ($past(t.busy) && !t.busy);
	endproperty
	a_done_after_busy: assert property (p_done_after_busy)
		else $error("timer done without a running count");
endmodule
`default_nettype wire

/* hdl/rps_top.sv */
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "rps_cfg.svh"

// Behaviour
// - power-on low: all off, no activity
// - power-on rise: digital regulators on, reset
// - analog regulator on only with RF active
// - brownout starts full digital and config reset
// - during brownout alert held low
// - recovery: alert high pulse, then reset hold
// - leaving reset: status bytes all ones, alert low
// - after reset enter sleep, accept commands
// - first status read releases alert high
// - sleep and polling off: oscillator low power
// - wake: settle oscillator, RF/PLL, then ready
// - alert events and polarity configurable
// - status returned only on controller request
// - self polling cycles configs on schedule
// - first event after reset clears, raises alert
// - reading a status byte clears it
// - power-on low: alert pin high impedance
module rps_top #(
	parameter int unsigned TW         = `RPS_TMR_W,
	parameter int unsigned RESET_CYC  = `RPS_RESET_CYC,
	parameter int unsigned PULSE_CYC  = `RPS_PULSE_CYC,
	parameter int unsigned SETTLE_CYC = `RPS_OSC_SETTLE_CYC,
	parameter int unsigned RFUP_CYC   = `RPS_RF_UP_CYC
) (
	input  wire logic        clk,             // core clock, 250 MHz
	input  wire logic        arst_n,          // async reset
	input  wire logic        power_on_i,      // power-on pin, async
	input  wire logic        brownout_i,      // supply below brownout, async
	input  wire logic [15:0] irq_event_i,     // event pulses, core clock
	input  wire logic [7:0]  s_axi_awaddr,    // write address
	input  wire logic        s_axi_awvalid,   // write address valid
	output logic             s_axi_awready,   // write address ready
	input  wire logic [31:0] s_axi_wdata,     // write data
	input  wire logic [3:0]  s_axi_wstrb,     // write strobes
	input  wire logic        s_axi_wvalid,    // write data valid
	output logic             s_axi_wready,    // write data ready
	output logic [1:0]       s_axi_bresp,     // write response
	output logic             s_axi_bvalid,    // write response valid
	input  wire logic        s_axi_bready,    // write response ready
	input  wire logic [7:0]  s_axi_araddr,    // read address
	input  wire logic        s_axi_arvalid,   // read address valid
	output logic             s_axi_arready,   // read address ready
	output logic [31:0]      s_axi_rdata,     // read data
	output logic [1:0]       s_axi_rresp,     // read response
	output logic             s_axi_rvalid,    // read data valid
	input  wire logic        s_axi_rready,    // read data ready
	output logic             dig_reg_en_o,    // digital regulators on
	output logic             ana_reg_en_o,    // analog regulator on
	output logic             core_rst_n_o,    // digital core reset
	output logic             osc_low_power_o, // oscillator low power, caps off
	output logic             rf_path_en_o,    // RF/IF path on
	output logic             pll_en_o,        // RF PLL on
	output logic             rx_ready_o,      // receiver ready
	output logic [1:0]       config_sel_o,    // active configuration set
	output rps_pkg::rps_state_t seq_state_o,  // sequencer state
	output logic             alert_out_n,     // alert pin level
	output logic             alert_oe_n,      // alert pin enable, low drives
	output logic             irq_o            // masked status interrupt
);
	import rps_pkg::*;

	logic            pwr_s;
	logic            brown_s;
	rps_state_t      state_reg;
	rps_state_t      state_next;
	rps_mode_t       mode;
	logic [7:0]      ctrl_reg;
	logic [7:0]      stat_reg [2];
	logic [7:0]      stat_next [2];
	logic [7:0]      mask_reg [2];
	logic [15:0]     on_reg;
	logic [15:0]     off_reg;
	logic [15:0]     phase_reg;
	logic [1:0]      cfg_idx_reg;
	logic            cfg_step;
	logic            post_reset_reg;
	logic            post_next;
	logic            rst_any;
	logic            first_evt;
	logic            first_rd;
	logic            act_next;
	logic            rf_on;
	logic            aw_have;
	logic            w_have;
	logic [7:0]      aw_addr;
	logic [31:0]     w_data;
	logic [3:0]      w_strb;
	logic            do_wr;
	logic            rd_hs;
	logic            rd_stat;
	logic [31:0]     rd_data;

	rps_timer_if #(.W(TW)) rst_t ();
	rps_timer_if #(.W(TW)) osc_t ();

	function automatic logic addr_hit(input logic [7:0] a);
		return a inside {`RPS_OFS_CTRL, `RPS_OFS_STAT0, `RPS_OFS_STAT1, `RPS_OFS_MASK0,
			`RPS_OFS_MASK1, `RPS_OFS_STATE, `RPS_OFS_ON, `RPS_OFS_OFF};
	endfunction

	function automatic logic [7:0] stat_ofs(input int i);
		return (i == 0) ? `RPS_OFS_STAT0 : `RPS_OFS_STAT1;
	endfunction

	function automatic logic is_rst(input rps_state_t s);
		return s inside {RPS_ST_OFF, RPS_ST_BROWN, RPS_ST_PULSE, RPS_ST_HOLD};
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	rps_sync #(.W(2)) u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.d      ({power_on_i, brownout_i}),
		.q      ({pwr_s, brown_s})
	);

	rps_timer u_rst_tmr (
		.clk    (clk),
		.arst_n (arst_n),
		.t      (rst_t.tmr)
	);

	rps_timer u_osc_tmr (
		.clk    (clk),
		.arst_n (arst_n),
		.t      (osc_t.tmr)
	);

	assign mode         = rps_mode_t'(ctrl_reg[1:0]);
	assign seq_state_o  = state_reg;
	assign config_sel_o = cfg_idx_reg;
	assign do_wr        = aw_have && w_have && !s_axi_bvalid;
	assign rd_hs        = s_axi_arvalid && s_axi_arready;
	assign rd_stat      = rd_hs && (s_axi_araddr inside {`RPS_OFS_STAT0, `RPS_OFS_STAT1});
	assign rf_on        = state_next inside {RPS_ST_RFUP, RPS_ST_RX};

	// sequencer; power-on beats brownout, brownout beats everything else
	always_comb begin
		state_next  = state_reg;
		rst_t.start = 1'b0;
		rst_t.load  = TW'(RESET_CYC);
		osc_t.start = 1'b0;
		osc_t.load  = TW'(SETTLE_CYC);
		cfg_step    = 1'b0;
		if (!pwr_s) begin
			state_next = RPS_ST_OFF;
		end else if (brown_s) begin
			state_next = RPS_ST_BROWN;
		end else begin
			unique case (state_reg)
				RPS_ST_OFF: begin
					state_next  = RPS_ST_HOLD;
					rst_t.start = 1'b1;
				end
				RPS_ST_BROWN: begin
					state_next  = RPS_ST_PULSE;
					rst_t.start = 1'b1;
					rst_t.load  = TW'(PULSE_CYC);
				end
				RPS_ST_PULSE: begin
					if (rst_t.done) begin
						state_next  = RPS_ST_HOLD;
						rst_t.start = 1'b1;
					end
				end
				RPS_ST_HOLD: begin
					if (rst_t.done) begin
						state_next = RPS_ST_SLEEP;
					end
				end
				RPS_ST_SLEEP: begin
					if (mode != RPS_MODE_SLEEP) begin
						state_next  = RPS_ST_SETTLE;
						osc_t.start = 1'b1;
					end
				end
				RPS_ST_SETTLE: begin
					if (osc_t.done) begin
						state_next  = RPS_ST_RFUP;
						osc_t.start = 1'b1;
						osc_t.load  = TW'(RFUP_CYC);
					end
				end
				RPS_ST_RFUP: begin
					if (osc_t.done) begin
						state_next = RPS_ST_RX;
					end
				end
				RPS_ST_RX: begin
					if (mode == RPS_MODE_SLEEP) begin
						state_next = RPS_ST_SLEEP;
					end else if (mode == RPS_MODE_POLL && phase_reg == 16'h0) begin
						cfg_step = 1'b1;
						if (cfg_idx_reg == ctrl_reg[3:2]) begin
							state_next = RPS_ST_POLL_OFF;
						end
					end
				end
				RPS_ST_POLL_OFF: begin
					if (mode == RPS_MODE_SLEEP) begin
						state_next = RPS_ST_SLEEP;
					end else if (mode != RPS_MODE_POLL || phase_reg == 16'h0) begin
						state_next  = RPS_ST_SETTLE;
						osc_t.start = 1'b1;
					end
				end
			endcase
		end
		rst_t.stop = !(state_next inside {RPS_ST_PULSE, RPS_ST_HOLD});
		osc_t.stop = !(state_next inside {RPS_ST_SETTLE, RPS_ST_RFUP});
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg       <= RPS_ST_OFF;
			dig_reg_en_o    <= 1'b0;
			core_rst_n_o    <= 1'b0;
			ana_reg_en_o    <= 1'b0;
			rf_path_en_o    <= 1'b0;
			pll_en_o        <= 1'b0;
			rx_ready_o      <= 1'b0;
			osc_low_power_o <= 1'b0;
		end else begin
			state_reg       <= state_next;
			dig_reg_en_o    <= state_next != RPS_ST_OFF;
			core_rst_n_o    <= !is_rst(state_next);
			ana_reg_en_o    <= rf_on;
			rf_path_en_o    <= rf_on;
			pll_en_o        <= rf_on;
			rx_ready_o      <= state_next == RPS_ST_RX;
			osc_low_power_o <= state_next inside {RPS_ST_SLEEP, RPS_ST_POLL_OFF};
		end
	end

	// on/off phase counter and configuration cycling in self polling
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_reg   <= 16'h0;
			cfg_idx_reg <= 2'h0;
		end else begin
			if (state_next == RPS_ST_RX && (state_reg != RPS_ST_RX || cfg_step)) begin
				phase_reg <= on_reg;
			end else if (state_next == RPS_ST_POLL_OFF && state_reg != RPS_ST_POLL_OFF) begin
				phase_reg <= off_reg;
			end else if (phase_reg != 16'h0) begin
				phase_reg <= phase_reg - 16'h1;
			end
			if (state_next inside {RPS_ST_SLEEP, RPS_ST_OFF, RPS_ST_BROWN}) begin
				cfg_idx_reg <= 2'h0;
			end else if (cfg_step) begin
				cfg_idx_reg <= (cfg_idx_reg == ctrl_reg[3:2]) ? 2'h0 : cfg_idx_reg + 2'h1;
			end
		end
	end

	// configuration is lost in any reset, as is the stored data
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg    <= `RPS_CTRL_RESET;
			mask_reg[0] <= `RPS_MASK_RESET;
			mask_reg[1] <= `RPS_MASK_RESET;
			on_reg      <= `RPS_ON_RESET;
			off_reg     <= `RPS_OFF_RESET;
		end else if (is_rst(state_reg)) begin
			ctrl_reg    <= `RPS_CTRL_RESET;
			mask_reg[0] <= `RPS_MASK_RESET;
			mask_reg[1] <= `RPS_MASK_RESET;
			on_reg      <= `RPS_ON_RESET;
			off_reg     <= `RPS_OFF_RESET;
		end else if (do_wr) begin
			if (aw_addr == `RPS_OFS_CTRL && w_strb[0]) begin
				ctrl_reg <= w_data[7:0] & `RPS_CTRL_WMASK;
			end
			if (aw_addr == `RPS_OFS_MASK0 && w_strb[0]) begin
				mask_reg[0] <= w_data[7:0];
			end
			if (aw_addr == `RPS_OFS_MASK1 && w_strb[0]) begin
				mask_reg[1] <= w_data[7:0];
			end
			if (aw_addr == `RPS_OFS_ON) begin
				on_reg <= merge16(on_reg, w_data, w_strb);
			end
			if (aw_addr == `RPS_OFS_OFF) begin
				off_reg <= merge16(off_reg, w_data, w_strb);
			end
		end
	end

	// status bytes: read clears, write-one clears, a new event still wins except the first event after reset, which clears both bytes
	always_comb begin
		rst_any   = is_rst(state_reg) || is_rst(state_next);
		first_evt = post_reset_reg && (|irq_event_i) && !rst_any;
		first_rd  = post_reset_reg && rd_stat && !rst_any;
		for (int i = 0; i < 2; i++) begin
			stat_next[i] = stat_reg[i];
			if (rd_hs && s_axi_araddr == stat_ofs(i)) begin
				stat_next[i] = 8'h00;
			end
			if (do_wr && w_strb[0] && aw_addr == stat_ofs(i)) begin
				stat_next[i] = stat_next[i] & ~w_data[7:0];
			end
			if (first_evt) begin
				stat_next[i] = 8'h00;
			end else begin
				stat_next[i] = stat_next[i] | irq_event_i[8*i +: 8];
			end
			if (rst_any) begin
				stat_next[i] = `RPS_STAT_RESET;
			end
		end
		if (rst_any) begin
			post_next = state_reg == RPS_ST_HOLD && state_next == RPS_ST_SLEEP;
		end else if (first_evt || first_rd) begin
			post_next = 1'b0;
		end else begin
			post_next = post_reset_reg;
		end
		act_next = (|(stat_next[0] & mask_reg[0])) || (|(stat_next[1] & mask_reg[1]));
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stat_reg[0]    <= `RPS_STAT_RESET;
			stat_reg[1]    <= `RPS_STAT_RESET;
			post_reset_reg <= 1'b0;
		end else begin
			stat_reg[0]    <= stat_next[0];
			stat_reg[1]    <= stat_next[1];
			post_reset_reg <= post_next;
		end
	end

	// reset states force the alert level regardless of the polarity setting
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			alert_out_n <= 1'b0;
			alert_oe_n  <= 1'b1;
			irq_o       <= 1'b0;
		end else begin
			alert_oe_n <= state_next == RPS_ST_OFF;
			irq_o      <= !rst_any && act_next;
			if (state_next == RPS_ST_PULSE) begin
				alert_out_n <= 1'b1;
			end else if (rst_any || post_next) begin
				alert_out_n <= 1'b0;
			end else begin
				alert_out_n <= ctrl_reg[`RPS_CTRL_POL_BIT] ? act_next : !act_next;
			end
		end
	end

	// write channel: address and data may arrive in either order
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RPS_RESP_OKAY;
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0;
			w_strb        <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_have       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
			end else if (!aw_have && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_have       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
			end else if (!w_have && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (do_wr) begin
				aw_have      <= 1'b0;
				w_have       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_hit(aw_addr) ? `RPS_RESP_OKAY : `RPS_RESP_DECERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		case (s_axi_araddr)
			`RPS_OFS_CTRL:  rd_data = {24'h0, ctrl_reg};
			`RPS_OFS_STAT0: rd_data = {24'h0, stat_reg[0]};
			`RPS_OFS_STAT1: rd_data = {24'h0, stat_reg[1]};
			`RPS_OFS_MASK0: rd_data = {24'h0, mask_reg[0]};
			`RPS_OFS_MASK1: rd_data = {24'h0, mask_reg[1]};
			`RPS_OFS_STATE: rd_data = {25'h0, post_reset_reg, cfg_idx_reg, state_reg};
			`RPS_OFS_ON:    rd_data = {16'h0, on_reg};
			`RPS_OFS_OFF:   rd_data = {16'h0, off_reg};
			default:        rd_data = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `RPS_RESP_OKAY;
		end else if (rd_hs) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_data;
			s_axi_rresp   <= addr_hit(s_axi_araddr) ? `RPS_RESP_OKAY : `RPS_RESP_DECERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	property p_off;
		@(posedge clk) disable iff (!arst_n)
		!pwr_s |=> (state_reg == RPS_ST_OFF && !dig_reg_en_o && alert_oe_n);
	endproperty
	a_off: assert property (p_off)
		else $error("power-on low but block not off");

	property p_por;
		@(posedge clk) disable iff (!arst_n)
		(state_reg == RPS_ST_OFF && pwr_s && !brown_s) |=> (dig_reg_en_o && !core_rst_n_o);
	endproperty
	a_por: assert property (p_por)
		else $error("power-on rise without regulators and reset");

	property p_analog;
		@(posedge clk) disable iff (!arst_n)
		ana_reg_en_o == (state_reg inside {RPS_ST_RFUP, RPS_ST_RX});
	endproperty
	a_analog: assert property (p_analog)
		else $error("analog regulator out of step with RF");

	property p_brown;
		@(posedge clk) disable iff (!arst_n)
		(pwr_s && brown_s) |=> (state_reg == RPS_ST_BROWN && !core_rst_n_o && !alert_out_n);
	endproperty
	a_brown: assert property (p_brown)
		else $error("brownout not holding reset and alert low");

	property p_pulse;
		@(posedge clk) disable iff (!arst_n)
		(state_reg == RPS_ST_BROWN && pwr_s && !brown_s) |=> alert_out_n && !core_rst_n_o;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("no alert pulse on brownout recovery");

	property p_leave;
		@(posedge clk) disable iff (!arst_n)
		(state_reg == RPS_ST_HOLD ##1 state_reg == RPS_ST_SLEEP) |->
			(stat_reg[0] == 8'hff && stat_reg[1] == 8'hff && !alert_out_n && core_rst_n_o);
	endproperty
	a_leave: assert property (p_leave)
		else $error("status or alert wrong after reset");

	property p_release;
		@(posedge clk) disable iff (!arst_n)
		(post_reset_reg && rd_stat && !rst_any && mask_reg[0] == 8'h00
			&& mask_reg[1] == 8'h00 && !ctrl_reg[`RPS_CTRL_POL_BIT]) |=> alert_out_n;
	endproperty
	a_release: assert property (p_release)
		else $error("first status read did not release alert");

	property p_first_evt;
		@(posedge clk) disable iff (!arst_n)
		first_evt |=> (stat_reg[0] == 8'h00 && stat_reg[1] == 8'h00 && !post_reset_reg);
	endproperty
	a_first_evt: assert property (p_first_evt)
		else $error("first event did not clear status");

	property p_osc;
		@(posedge clk) disable iff (!arst_n)
		(state_reg inside {RPS_ST_SLEEP, RPS_ST_POLL_OFF}) |-> osc_low_power_o && !rf_path_en_o;
	endproperty
	a_osc: assert property (p_osc)
		else $error("oscillator not low power in sleep");

	property p_wake;
		@(posedge clk) disable iff (!arst_n)
		$rose(rx_ready_o) |-> ($past(rf_path_en_o) && $past(pll_en_o) && !osc_low_power_o);
	endproperty
	a_wake: assert property (p_wake)
		else $error("receiver ready before RF path up");

	property p_rdclr;
		@(posedge clk) disable iff (!arst_n)
		(rd_hs && s_axi_araddr == `RPS_OFS_STAT0 && irq_event_i == 16'h0 && !rst_any)
			|=> stat_reg[0] == 8'h00;
	endproperty
	a_rdclr: assert property (p_rdclr)
		else $error("status byte not cleared by read");
endmodule
`default_nettype wire

/* tb/rps_mcu.sv */
`timescale 1ns/10ps
`default_nettype none
module rps_mcu (
	input  wire logic        clk,           // core clock
	output logic [7:0]       s_axi_awaddr,  // write address
	output logic             s_axi_awvalid, // write address valid
	input  wire logic        s_axi_awready, // write address ready
	output logic [31:0]      s_axi_wdata,   // write data
	output logic [3:0]       s_axi_wstrb,   // write strobes
	output logic             s_axi_wvalid,  // write data valid
	input  wire logic        s_axi_wready,  // write data ready
	input  wire logic        s_axi_bvalid,  // write response valid
	output logic             s_axi_bready,  // write response ready
	output logic [7:0]       s_axi_araddr,  // read address
	output logic             s_axi_arvalid, // read address valid
	input  wire logic        s_axi_arready, // read address ready
	input  wire logic [31:0] s_axi_rdata,   // read data
	input  wire logic        s_axi_rvalid,  // read data valid
	output logic             s_axi_rready   // read data ready
);
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		fork
			begin do @(posedge clk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
			begin do @(posedge clk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
		join
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	// status only ever comes back as the answer to a read request
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
	import rps_pkg::*;
	logic clk = 0, arst_n = 0, power_on_i = 0, brownout_i = 0;
	logic [15:0] irq_event_i = '0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic dig_reg_en_o, ana_reg_en_o, core_rst_n_o, osc_low_power_o, rf_path_en_o, pll_en_o;
	logic rx_ready_o, alert_out_n, alert_oe_n, irq_o;
	logic [1:0] config_sel_o, s_axi_bresp, s_axi_rresp;
	rps_state_t seq_state_o;
	int error_cnt = 0, comparisons = 0, cyc = 0;
	always #2 clk = ~clk;
	rps_top #(.RESET_CYC(20), .PULSE_CYC(4), .SETTLE_CYC(16), .RFUP_CYC(8)) dut_u (
		.clk, .arst_n, .power_on_i, .brownout_i, .irq_event_i, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dig_reg_en_o, .ana_reg_en_o, .core_rst_n_o,
		.osc_low_power_o, .rf_path_en_o, .pll_en_o, .rx_ready_o, .config_sel_o, .seq_state_o,
		.alert_out_n, .alert_oe_n, .irq_o);
	rps_mcu mcu (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// bounded wait; a miss shows up in the state compare that follows
	task automatic wait_st(input rps_state_t s);
		repeat (400) if (seq_state_o !== s) @(posedge clk);
		chk("state", 32'(s), 32'(seq_state_o));
	endtask
	task automatic conclude();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic t_power();
		repeat (8) @(posedge clk);
		chk("regs off", 32'h0, 32'(dig_reg_en_o));
		chk("pin hiz", 32'h1, 32'(alert_oe_n));
		power_on_i <= 1'b1;
		wait_st(RPS_ST_HOLD);
		chk("regs on in reset", 32'h1, 32'({core_rst_n_o, dig_reg_en_o}));
		wait_st(RPS_ST_SLEEP);
		chk("sleep outs", 32'h1, {alert_oe_n, alert_out_n, osc_low_power_o});
		chk("analog off", 32'h0, 32'(ana_reg_en_o));
		mcu.rd(8'h08, d);
		chk("stat1", 32'hff, d);
		repeat (3) @(posedge clk);
		chk("alert released", 32'h1, 32'(alert_out_n));
		mcu.rd(8'h08, d);
		chk("stat1 cleared", 32'h0, d);
		mcu.rd(8'h04, d);
		chk("stat0 kept", 32'hff, d);
		$display("power test done");
	endtask
	task automatic t_wake();
		mcu.wr(8'h00, 32'h1);
		wait_st(RPS_ST_SETTLE);
		chk("settle", 32'h0, {osc_low_power_o, rf_path_en_o, pll_en_o});
		wait_st(RPS_ST_RFUP);
		chk("rf up", 32'h6, {rf_path_en_o, pll_en_o, rx_ready_o});
		wait_st(RPS_ST_RX);
		chk("rx", 32'h3, {ana_reg_en_o, rx_ready_o});
		$display("wake test done");
	endtask
	// short on/off times so two configurations and an off phase fit in a few hundred cycles
	task automatic t_poll();
		mcu.wr(8'h18, 32'h10);
		mcu.wr(8'h1c, 32'h20);
		mcu.wr(8'h00, 32'h0);
		wait_st(RPS_ST_SLEEP);
		mcu.wr(8'h00, 32'h6);
		wait_st(RPS_ST_RX);
		chk("config", 32'h0, 32'(config_sel_o));
		repeat (20) @(posedge clk);
		chk("config next", 32'h1, 32'(config_sel_o));
		wait_st(RPS_ST_POLL_OFF);
		chk("poll off", 32'h4, 32'({osc_low_power_o, config_sel_o}));
		wait_st(RPS_ST_SETTLE);
		$display("polling test done");
	endtask
	task automatic t_irq();
		mcu.wr(8'h10, 32'h2);
		mcu.wr(8'h00, 32'h10);
		irq_event_i <= 16'h0200;
		@(posedge clk);
		irq_event_i <= 16'h0;
		repeat (3) @(posedge clk);
		chk("irq set", 32'h3, 32'({irq_o, alert_out_n}));
		mcu.wr(8'h08, 32'h2);
		repeat (3) @(posedge clk);
		chk("irq clear", 32'h0, 32'({irq_o, alert_out_n}));
		mcu.wr(8'h20, 32'h1);
		chk("bresp", 32'h3, 32'(s_axi_bresp));
		mcu.rd(8'h20, d);
		chk("rresp", 32'h3, 32'(s_axi_rresp));
		$display("interrupt test done");
	endtask
	task automatic t_brown();
		brownout_i <= 1'b1;
		wait_st(RPS_ST_BROWN);
		repeat (2) @(posedge clk);
		chk("brown", 32'h0, {alert_out_n, core_rst_n_o, rx_ready_o});
		brownout_i <= 1'b0;
		wait_st(RPS_ST_PULSE);
		repeat (2) @(posedge clk);
		chk("pulse", 32'h1, 32'(alert_out_n));
		wait_st(RPS_ST_SLEEP);
		mcu.rd(8'h00, d);
		chk("ctrl reset", 32'h0, d);
		irq_event_i <= 16'h0200;
		@(posedge clk);
		irq_event_i <= 16'h0;
		repeat (3) @(posedge clk);
		chk("first event", 32'h1, 32'(alert_out_n));
		mcu.rd(8'h04, d);
		chk("stat0 cleared", 32'h0, d);
		$display("brownout test done");
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		t_power();
		t_wake();
		t_poll();
		t_brown();
		t_irq();
		conclude();
	end
endmodule
`default_nettype wire
